/* hw/msc_pkg.sv */
// Constants, register map and bus carrier for the MAC security command block
package msc_pkg;
  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_TXCTL = 8'h04;
  localparam logic [7:0] OFS_STS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_KEY = 8'h10;
  localparam logic [7:0] OFS_PTR = 8'h14;
  localparam logic [7:0] OFS_DATA = 8'h18;
  localparam logic [7:0] OFS_LEN = 8'h1C;
  // Command register fields
  localparam int CMD_DEC_BIT = 5;
  localparam int CMD_ENC_BIT = 4;
  localparam logic [1:0] CMD_RSVD_HI = 2'h3;
  localparam logic [1:0] CMD_RSVD_MID = 2'h1;
  // Transmit path control fields
  localparam int TXCTL_ON_BIT = 1;
  localparam int TXCTL_OFF_BIT = 0;
  // Status / mask fields
  localparam int STS_ENC_DONE = 0;
  localparam int STS_DEC_DONE = 1;
  localparam int STS_BUSY_BIT = 4;
  localparam int EVT_W = 2;
  // Buffer pointer: bit 8 picks the receive side
  localparam int PTR_SIDE_BIT = 8;
  localparam int PTR_W = 9;
  // Reset values
  localparam logic [EVT_W-1:0] MASK_RST = 2'h0;
  localparam logic [7:0] KEY_RST = 8'h00;
  localparam logic [7:0] LEN_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 9'h000;
  // Buffer geometry defaults
  localparam int BUF_W = 8;
  localparam int BUF_DEPTH = 256;

  // One register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } msc_bus_req_t;
endpackage

/* hw/msc_buf_mem.sv */
// Byte buffer with one write port and one read port, registered write-first read data
`timescale 1ns/1ps
`default_nettype none
module msc_buf_mem #(
  parameter int W = 8,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Access port
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr, // Write address
  input wire logic [AW-1:0] i_raddr, // Read address
  input wire logic [W-1:0] i_wdata,
  output logic [W-1:0] o_rdata
);
  // Storage array, no reset needed for data
  logic [W-1:0] mem [DEPTH];

  // Write port
  always_ff @(posedge i_ref_clk)
  begin
    if (i_we)
      mem[i_addr] <= i_wdata;
  end

  // Read register; a write to the byte being read forwards its data, so no stale bytes
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_rdata <= '0;
    else if (i_we && (i_addr == i_raddr))
      o_rdata <= i_wdata;
    else
      o_rdata <= mem[i_raddr];
  end
endmodule // msc_buf_mem
`default_nettype wire

/* hw/msc_top.sv */
// MAC security command register, in-place buffer cipher walk and transmit path select
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module msc_top #(
  parameter int BUF_W = msc_pkg::BUF_W,
  parameter int BUF_DEPTH = msc_pkg::BUF_DEPTH
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Register bus
  input wire msc_pkg::msc_bus_req_t i_bus,
  output logic [msc_pkg::DATA_W-1:0] o_rd_data,
  // Modem transmit path
  input wire logic i_auto_mod_en,
  output logic o_mod_en,
  // Interrupt
  output logic o_irq
);
  localparam int AW = $clog2(BUF_DEPTH);

  // Engine states
  typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE} msc_state_t;

  // Software visible state
  logic dec_start_r;
  logic enc_start_r;
  logic force_on_r;
  logic force_off_r;
  logic [msc_pkg::EVT_W-1:0] sts_r;
  logic [msc_pkg::EVT_W-1:0] mask_r;
  logic [7:0] key_r;
  logic [7:0] len_r;
  logic [msc_pkg::PTR_W-1:0] ptr_r;
  // Requests waiting for the engine
  logic dec_pend_r;
  logic enc_pend_r;
  // Engine state
  msc_state_t state_r;
  msc_state_t state_nxt;
  logic side_r;
  logic [AW-1:0] idx_r;

  // Address decode
  wire wr_cmd = i_bus.wr && (i_bus.addr == msc_pkg::OFS_CMD);
  wire wr_txctl = i_bus.wr && (i_bus.addr == msc_pkg::OFS_TXCTL);
  wire wr_mask = i_bus.wr && (i_bus.addr == msc_pkg::OFS_MASK);
  wire wr_key = i_bus.wr && (i_bus.addr == msc_pkg::OFS_KEY);
  wire wr_ptr = i_bus.wr && (i_bus.addr == msc_pkg::OFS_PTR);
  wire wr_len = i_bus.wr && (i_bus.addr == msc_pkg::OFS_LEN);
  wire wr_data = i_bus.wr && (i_bus.addr == msc_pkg::OFS_DATA);
  wire rd_data = i_bus.rd && (i_bus.addr == msc_pkg::OFS_DATA);
  wire rd_sts = i_bus.rd && (i_bus.addr == msc_pkg::OFS_STS);

  // Engine status
  wire busy = (state_r != S_IDLE);
  wire last = ((idx_r + 1'b1) == len_r[AW-1:0]);
  wire fin = (state_r == S_WRITE) && last;
  wire take = !busy && (dec_pend_r || enc_pend_r);
  // Decryption is served first when both wait
  wire take_dec = dec_pend_r;

  // Buffer access by software is ignored while the engine owns the buffers
  wire buf_acc = (wr_data || rd_data) && !busy;
  wire [msc_pkg::PTR_W-1:0] ptr_inc = {ptr_r[msc_pkg::PTR_SIDE_BIT], ptr_r[7:0] + 8'h01};
  wire [msc_pkg::PTR_W-1:0] ptr_nxt = wr_ptr ? i_bus.wdata[msc_pkg::PTR_W-1:0] :
                                      buf_acc ? ptr_inc : ptr_r;

  // Start requests: only a zero-to-one write of a start bit queues work
  wire dec_rise = wr_cmd && i_bus.wdata[msc_pkg::CMD_DEC_BIT] && !dec_start_r;
  wire enc_rise = wr_cmd && i_bus.wdata[msc_pkg::CMD_ENC_BIT] && !enc_start_r;

  // Completion events; a set in the same cycle as a clearing read wins
  wire [msc_pkg::EVT_W-1:0] evt_set;
  assign evt_set[msc_pkg::STS_DEC_DONE] = fin && side_r;
  assign evt_set[msc_pkg::STS_ENC_DONE] = fin && !side_r;
  wire [msc_pkg::EVT_W-1:0] sts_nxt = (rd_sts ? '0 : sts_r) | evt_set;

  // Modulator enable select: force on beats force off, neither lets the modem decide
  wire mod_en_nxt = force_on_r ? 1'b1 : force_off_r ? 1'b0 : i_auto_mod_en;

  // Buffer ports, side 0 transmit, side 1 receive
  logic [1:0] mem_we;
  logic [AW-1:0] mem_addr [2];
  logic [AW-1:0] mem_raddr [2];
  logic [BUF_W-1:0] mem_wdata [2];
  logic [BUF_W-1:0] mem_q [2];

  // One buffer per side; the engine takes over the side it works on
  for (genvar s = 0; s < 2; s++)
  begin : g_buf
    wire eng = busy && (side_r == 1'(s));
    // Software writes land at the current pointer
    assign mem_addr[s] = eng ? idx_r : ptr_r[AW-1:0];
    // Software reads pre-fetch at the next pointer so data is ready a cycle later
    assign mem_raddr[s] = eng ? idx_r : ptr_nxt[AW-1:0];
    // Result replaces its source byte in place
    assign mem_we[s] = eng ? (state_r == S_WRITE) :
                       (wr_data && !busy && (ptr_r[msc_pkg::PTR_SIDE_BIT] == 1'(s)));
    // Byte-wise keystream stand-in for the cipher core
    assign mem_wdata[s] = eng ? (mem_q[s] ^ key_r[BUF_W-1:0]) : i_bus.wdata[BUF_W-1:0];
    msc_buf_mem #(
      .W(BUF_W),
      .DEPTH(BUF_DEPTH),
      .AW(AW)
    ) u_mem (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_we(mem_we[s]),
      .i_addr(mem_addr[s]),
      .i_raddr(mem_raddr[s]),
      .i_wdata(mem_wdata[s]),
      .o_rdata(mem_q[s])
    );
  end

  // Read data select; unmapped addresses read zero
  wire [7:0] cmd_val = {msc_pkg::CMD_RSVD_HI, dec_start_r, enc_start_r,
                        msc_pkg::CMD_RSVD_MID, 2'h0};
  wire [7:0] txctl_val = {6'h00, force_on_r, force_off_r};
  wire [7:0] sts_val = {3'h0, busy, 2'h0, sts_r};
  wire [7:0] mask_val = {6'h00, mask_r};
  wire [BUF_W-1:0] data_val = busy ? '0 : mem_q[ptr_r[msc_pkg::PTR_SIDE_BIT]];
  wire [msc_pkg::DATA_W-1:0] rd_val =
    (i_bus.addr == msc_pkg::OFS_CMD) ? {24'h00_0000, cmd_val} :
    (i_bus.addr == msc_pkg::OFS_TXCTL) ? {24'h00_0000, txctl_val} :
    (i_bus.addr == msc_pkg::OFS_STS) ? {24'h00_0000, sts_val} :
    (i_bus.addr == msc_pkg::OFS_MASK) ? {24'h00_0000, mask_val} :
    (i_bus.addr == msc_pkg::OFS_KEY) ? {24'h00_0000, key_r} :
    (i_bus.addr == msc_pkg::OFS_PTR) ? {23'h00_0000, ptr_r} :
    (i_bus.addr == msc_pkg::OFS_LEN) ? {24'h00_0000, len_r} :
    (i_bus.addr == msc_pkg::OFS_DATA) ? {{(msc_pkg::DATA_W-BUF_W){1'b0}}, data_val} :
    32'h0000_0000;

  // Engine next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE:
        if (take)
          state_nxt = S_READ;
      S_READ:
        state_nxt = S_WRITE;
      S_WRITE:
        state_nxt = last ? S_IDLE : S_READ;
    endcase
  end

  // Command start bits hold until software writes them to zero
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      dec_start_r <= 1'b0;
      enc_start_r <= 1'b0;
    end
    else if (wr_cmd)
    begin
      dec_start_r <= i_bus.wdata[msc_pkg::CMD_DEC_BIT];
      enc_start_r <= i_bus.wdata[msc_pkg::CMD_ENC_BIT];
    end
  end

  // Pending requests; a new request in the cycle of its take is kept
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      dec_pend_r <= 1'b0;
      enc_pend_r <= 1'b0;
    end
    else
    begin
      dec_pend_r <= dec_rise || (dec_pend_r && !(take && take_dec));
      enc_pend_r <= enc_rise || (enc_pend_r && !(take && !take_dec));
    end
  end

  // Configuration registers
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      force_on_r <= 1'b0;
      force_off_r <= 1'b0;
      mask_r <= msc_pkg::MASK_RST;
      key_r <= msc_pkg::KEY_RST;
      len_r <= msc_pkg::LEN_RST;
      ptr_r <= msc_pkg::PTR_RST;
    end
    else
    begin
      if (wr_txctl)
      begin
        force_on_r <= i_bus.wdata[msc_pkg::TXCTL_ON_BIT];
        force_off_r <= i_bus.wdata[msc_pkg::TXCTL_OFF_BIT];
      end
      if (wr_mask)
        mask_r <= i_bus.wdata[msc_pkg::EVT_W-1:0];
      if (wr_key)
        key_r <= i_bus.wdata[7:0];
      if (wr_len)
        len_r <= i_bus.wdata[7:0];
      ptr_r <= ptr_nxt;
    end
  end

  // Engine registers; the length is sampled live, so do not change it mid-job
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_r <= S_IDLE;
      side_r <= 1'b0;
      idx_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (take)
      begin
        side_r <= take_dec;
        idx_r <= '0;
      end
      else if (state_r == S_WRITE)
        idx_r <= idx_r + 1'b1;
    end
  end

  // Status, interrupt, modulator enable and read data, all registered
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sts_r <= '0;
      o_irq <= 1'b0;
      o_mod_en <= 1'b0;
      o_rd_data <= '0;
    end
    else
    begin
      sts_r <= sts_nxt;
      o_irq <= |(sts_nxt & mask_r);
      o_mod_en <= mod_en_nxt;
      o_rd_data <= i_bus.rd ? rd_val : '0;
    end
  end
endmodule // msc_top
`default_nettype wire

/* verification/msc_top_properties.sv */
// Port-level properties of the security command block
`timescale 1ns/1ps
`default_nettype none
module msc_top_properties (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Watched ports
  input wire msc_pkg::msc_bus_req_t i_bus,
  input wire logic [msc_pkg::DATA_W-1:0] o_rd_data,
  input wire logic i_auto_mod_en,
  input wire logic o_mod_en,
  input wire logic o_irq
);
  // Software writes per register
  wire logic wr_cmd = i_bus.wr && (i_bus.addr == msc_pkg::OFS_CMD);
  wire logic wr_ctl = i_bus.wr && (i_bus.addr == msc_pkg::OFS_TXCTL);
  wire logic wr_msk = i_bus.wr && (i_bus.addr == msc_pkg::OFS_MASK);
  logic [1:0] ctl_r; // Force on, force off
  logic [1:0] msk_r; // Mask copy
  logic [1:0] cmd_r; // Decrypt start, encrypt start
  // Mirrors come from the bus, so no design internals are needed
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctl_r <= 2'h0;
      msk_r <= 2'h0;
      cmd_r <= 2'h0;
    end
    else
    begin
      ctl_r <= wr_ctl ? i_bus.wdata[1:0] : ctl_r;
      msk_r <= wr_msk ? i_bus.wdata[1:0] : msk_r;
      cmd_r <= wr_cmd ? i_bus.wdata[5:4] : cmd_r;
    end
  end
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  a_mod_auto_follow: assert property (ctl_r == 2'h0 && $stable(ctl_r) && $stable(i_auto_mod_en)
    |=> o_mod_en == $past(i_auto_mod_en))
    else $error("modulator enable ignores modem control");
  a_mod_force_wins: assert property (ctl_r != 2'h0 && $stable(ctl_r)
    |=> o_mod_en == $past(ctl_r[1]))
    else $error("modulator force setting ignored");
  a_rd_idle_zero: assert property (!i_bus.rd |=> o_rd_data == '0)
    else $error("read data outside read cycle");
  a_cmd_bits_latched: assert property (i_bus.rd && i_bus.addr == msc_pkg::OFS_CMD
    |=> o_rd_data == {24'h0, 2'h3, $past(cmd_r), 4'h4})
    else $error("command readback wrong");
  a_masked_irq_low: assert property (msk_r == 2'h0 && $past(msk_r) == 2'h0 |=> !o_irq)
    else $error("interrupt while fully masked");
  a_enc_done_irq: assert property (wr_cmd && i_bus.wdata[4] && !cmd_r[0] && msk_r[0]
    |-> ##[1:1000] o_irq)
    else $error("no encrypt completion interrupt");
  a_dec_done_irq: assert property (wr_cmd && i_bus.wdata[5] && !cmd_r[1] && msk_r[1]
    |-> ##[1:1000] o_irq)
    else $error("no decrypt completion interrupt");
endmodule // msc_top_properties
bind msc_top msc_top_properties u_props (
  .i_ref_clk(i_ref_clk),
  .i_nrst(i_nrst),
  .i_bus(i_bus),
  .o_rd_data(o_rd_data),
  .i_auto_mod_en(i_auto_mod_en),
  .o_mod_en(o_mod_en),
  .o_irq(o_irq)
);
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the security command block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
  // Stimulus and observed ports
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  msc_pkg::msc_bus_req_t i_bus = '0;
  logic i_auto_mod_en = 1'b0;
  logic [msc_pkg::DATA_W-1:0] o_rd_data;
  logic o_mod_en;
  logic o_irq;
  int err_count = 0;
  int n_checks = 0;
  // 50 MHz clock
  always #10 i_ref_clk = ~i_ref_clk;
  msc_top dut (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_bus(i_bus),
    .o_rd_data(o_rd_data),
    .i_auto_mod_en(i_auto_mod_en),
    .o_mod_en(o_mod_en),
    .o_irq(o_irq)
  );
  // Verdict and end of run
  task automatic tally_and_finish();
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [8:0] d);
    @(posedge i_ref_clk);
    i_bus.wr <= 1'b1;
    i_bus.addr <= a;
    i_bus.wdata <= {23'h0, d};
    @(posedge i_ref_clk);
    i_bus.wr <= 1'b0;
  endtask
  // Read; data stands only in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    i_bus.rd <= 1'b1;
    i_bus.addr <= a;
    @(posedge i_ref_clk);
    i_bus.rd <= 1'b0;
    #1 `CHK($sformatf("reg %h", a), e, o_rd_data)
  endtask
  // Bounded wait; a hang closes the run as a failure
  task automatic wait_irq();
    int i;
    for (i = 0; i < 600 && o_irq !== 1'b1; i++) @(posedge i_ref_clk);
    if (o_irq !== 1'b1)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // Fill four bytes, start a job, then check status, latch and in-place result
  task automatic job(input logic [8:0] p, input logic [7:0] c, input logic ie,
    input logic [31:0] sts);
    int i;
    wr(msc_pkg::OFS_PTR, p);
    for (i = 0; i < 4; i++) wr(msc_pkg::OFS_DATA, {1'b0, 4'(i), 4'h3});
    wr(msc_pkg::OFS_CMD, {1'b0, c});
    ticks(2);
    rd(msc_pkg::OFS_STS, 32'h0000_0010);
    if (ie)
      wait_irq();
    else
      ticks(12);
    `CHK("irq", ie, o_irq)
    rd(msc_pkg::OFS_STS, sts);
    `CHK("irq", 1'b0, o_irq)
    rd(msc_pkg::OFS_CMD, 32'h0000_00C4 | {24'h0, c});
    wr(msc_pkg::OFS_PTR, p);
    for (i = 0; i < 4; i++) rd(msc_pkg::OFS_DATA, {24'h0, {4'(i), 4'h3} ^ 8'h5A});
  endtask
  initial
  begin
    int c;
    ticks(5);
    i_nrst <= 1'b1;
    rd(msc_pkg::OFS_CMD, 32'h0000_00C4);
    rd(msc_pkg::OFS_STS, 32'h0000_0000);
    wr(8'h20, 9'h055);
    rd(8'h20, 32'h0000_0000);
    // Every force combination against both modem levels
    for (c = 0; c < 8; c++)
    begin
      wr(msc_pkg::OFS_TXCTL, {7'h0, c[1:0]});
      i_auto_mod_en <= c[2];
      ticks(3);
      `CHK("mod_en", c[1] ? 1'b1 : (c[0] ? 1'b0 : c[2]), o_mod_en)
    end
    wr(msc_pkg::OFS_KEY, 9'h05A);
    wr(msc_pkg::OFS_LEN, 9'h004);
    wr(msc_pkg::OFS_MASK, 9'h003);
    job(9'h000, 8'h10, 1'b1, 32'h0000_0001);
    // Rewriting a set start bit must not queue a job
    wr(msc_pkg::OFS_CMD, 9'h010);
    ticks(12);
    rd(msc_pkg::OFS_STS, 32'h0000_0000);
    wr(msc_pkg::OFS_CMD, 9'h000);
    wr(msc_pkg::OFS_MASK, 9'h001);
    job(9'h100, 8'h20, 1'b0, 32'h0000_0002);
    wr(msc_pkg::OFS_CMD, 9'h000);
    // Unmasked decryption must raise the completion interrupt
    wr(msc_pkg::OFS_MASK, 9'h003);
    job(9'h100, 8'h20, 1'b1, 32'h0000_0002);
    wr(msc_pkg::OFS_CMD, 9'h000);
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
